// >>> aphi_pkg.sv
// Package with constants and carrier types of the parallel host port.
package aphi_pkg;

    localparam int CHAN_COUNT  = 8;
    localparam int DATA_W      = 16;
    localparam int ADDR_W      = 7;
    localparam int FIFO_DEPTH  = 8;

    localparam int CMD_RW_BIT  = 15;
    localparam int CMD_ADDR_HI = 14;
    localparam int CMD_ADDR_LO = 8;

    localparam int HDR_RESET_BIT = 7;
    localparam int HDR_FAULT_BIT = 6;
    localparam int HDR_OPEN_BIT  = 5;

    localparam logic [2:0]  CHAN_TAG_FIRST = 3'h0;
    localparam logic [2:0]  CHAN_TAG_LAST  = 3'h7;
    localparam logic [7:0]  REG_RESET_VAL  = 8'h00;
    localparam logic [15:0] CRC_SEED       = 16'hFFFF;
    localparam logic [15:0] CRC_POLY       = 16'h1021;
    localparam logic [15:0] BUS_ZERO       = 16'h0000;

    typedef struct packed {
        logic       nCs;
        logic       nRd;
        logic       nWr;
        logic       busy;
    } aphi_strobe_s;

    typedef struct packed {
        logic [DATA_W-1:0] value;
        logic              resetSeen;
        logic              digitalFault;
        logic              openInput;
    } aphi_sample_s;

    typedef enum logic [2:0] {
        ST_ADC_DATA   = 3'b001,
        ST_ADC_STATUS = 3'b010,
        ST_ADC_CRC    = 3'b100
    } aphi_frame_e;

endpackage

// >>> aphi_fifo.sv
// Parameterised valid and ready FIFO.
`timescale 1ns/1ps
module aphi_fifo #(
    parameter int WIDTH = 19,
    parameter int DEPTH = 8
) (
    input  wire logic             mclk,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic      [WIDTH-1:0] outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_q;
    logic [AW-1:0]    rdPtr_q;
    logic [AW:0]      count_q;
    logic             doPush;
    logic             doPop;
    logic             ready_q;

    assign inReady  = ready_q;
    assign outValid = (count_q != '0);
    assign outData  = mem[rdPtr_q];
    assign doPush   = inValid && inReady;
    assign doPop    = outValid && outReady;

    always_ff @(posedge mclk) begin
        if (doPush) begin
            mem[wrPtr_q] <= inData;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
            ready_q <= 1'b1;
        end else begin
            if (doPush) begin
                wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
            end
            if (doPop) begin
                rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
            end
            if (doPush && !doPop) begin
                count_q <= count_q + 1'b1;
                ready_q <= (count_q != (AW+1)'(DEPTH-1));
            end else if (doPop && !doPush) begin
                count_q <= count_q - 1'b1;
                ready_q <= 1'b1;
            end
        end
    end

endmodule // aphi_fifo

// >>> aphi_host_port.sv
// Parallel host port: result readout, status header, CRC and register mode.
`timescale 1ns/1ps
module aphi_host_port (
    input  wire logic                      mclk,
    input  wire logic                      rstn,
    input  wire logic                      interfaceSelectStrap,
    input  wire logic [2:0]                oversamplingSelectPins,
    input  wire logic                      nCs,
    input  wire logic                      nRd,
    input  wire logic                      nWr,
    input  wire logic                      busy,
    input  wire logic [15:0]               parallelDataBusIn,
    output logic      [15:0]               parallelDataBusOut,
    output logic                           parallelDataBusOe,
    output logic                           firstChannelFlagOut,
    output logic                           firstChannelFlagOe,
    input  wire aphi_pkg::aphi_sample_s    sampleIn,
    input  wire logic                      sampleValid,
    output logic                           sampleReady,
    input  wire logic                      statusEnable,
    input  wire logic                      crcEnable,
    input  wire logic [7:0]                regReadData,
    output logic      [6:0]                regAddr,
    output logic      [7:0]                regWriteData,
    output logic                           regWriteStrobe,
    output logic                           registerMode
);
    import aphi_pkg::*;

    // ************************************************************
    // Input synchronisers.
    // ************************************************************
    localparam int SYNC_W = 20;
    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    logic [SYNC_W-1:0] sync3_q;
    logic [SYNC_W-1:0] pinsRaw;
    aphi_strobe_s      strobe_q;
    aphi_strobe_s      strobePrev_q;
    logic [15:0]       busIn_q;

    assign pinsRaw = {nCs, nRd, nWr, busy, parallelDataBusIn};

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sync1_q <= {4'hE, BUS_ZERO};
            sync2_q <= {4'hE, BUS_ZERO};
            sync3_q <= {4'hE, BUS_ZERO};
        end else begin
            sync1_q <= pinsRaw;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // A strobe change counts only once the second and third stages agree.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            strobe_q     <= '{nCs: 1'b1, nRd: 1'b1, nWr: 1'b1, busy: 1'b0};
            strobePrev_q <= '{nCs: 1'b1, nRd: 1'b1, nWr: 1'b1, busy: 1'b0};
            busIn_q      <= BUS_ZERO;
        end else begin
            if (sync2_q[19] == sync3_q[19]) strobe_q.nCs  <= sync3_q[19];
            if (sync2_q[18] == sync3_q[18]) strobe_q.nRd  <= sync3_q[18];
            if (sync2_q[17] == sync3_q[17]) strobe_q.nWr  <= sync3_q[17];
            if (sync2_q[16] == sync3_q[16]) strobe_q.busy <= sync3_q[16];
            busIn_q      <= sync3_q[15:0];
            strobePrev_q <= strobe_q;
        end
    end

    logic rdFall;
    logic wrRise;
    logic busyFall;
    logic parallelSel;
    logic softwareMode;

    assign rdFall       = strobePrev_q.nRd && !strobe_q.nRd && !strobe_q.nCs;
    assign wrRise       = !strobePrev_q.nWr && strobe_q.nWr && !strobe_q.nCs;
    assign busyFall     = strobePrev_q.busy && !strobe_q.busy;
    assign parallelSel  = !interfaceSelectStrap;
    assign softwareMode = (oversamplingSelectPins == 3'h7);

    // ************************************************************
    // CRC step.
    // ************************************************************
    function automatic logic [15:0] crcStep(input logic [15:0] crc, input logic [15:0] word);
        logic [15:0] c;
        c = crc;
        for (int i = 15; i >= 0; i--) begin
            c = (c[15] ^ word[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        return c;
    endfunction

    // ************************************************************
    // Sample FIFO and output result registers.
    // ************************************************************
    aphi_sample_s fifoOut;
    logic         fifoValid;
    logic         fifoPop;
    aphi_sample_s result_q [CHAN_COUNT];
    logic [2:0]   loadIdx_q;
    logic         loading_q;

    aphi_fifo #(
        .WIDTH ($bits(aphi_sample_s)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk     (mclk),
        .rstn     (rstn),
        .inData   (sampleIn),
        .inValid  (sampleValid),
        .inReady  (sampleReady),
        .outData  (fifoOut),
        .outValid (fifoValid),
        .outReady (fifoPop)
    );

    // Conversion words drain into the result registers only after busy falls.
    assign fifoPop = loading_q && fifoValid;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            loading_q <= 1'b0;
            loadIdx_q <= CHAN_TAG_FIRST;
        end else if (busyFall) begin
            loading_q <= 1'b1;
            loadIdx_q <= CHAN_TAG_FIRST;
        end else if (fifoPop) begin
            loadIdx_q <= loadIdx_q + 3'h1;
            if (loadIdx_q == CHAN_TAG_LAST) loading_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (fifoPop) result_q[loadIdx_q] <= fifoOut;
    end

    // ************************************************************
    // ADC readout sequencer.
    // ************************************************************
    aphi_frame_e frame_q;
    logic [2:0]  chan_q;
    logic [15:0] crc_q;
    logic [15:0] nextWord;
    logic        stepOk;
    logic        useStatus;
    logic        useCrc;

    assign useStatus = softwareMode && statusEnable;
    assign useCrc    = softwareMode && crcEnable;
    assign stepOk    = parallelSel && !registerMode && rdFall;

    always_comb begin
        nextWord = BUS_ZERO;
        case (frame_q)
            ST_ADC_DATA: begin
                nextWord = result_q[chan_q].value;
            end
            ST_ADC_STATUS: begin
                nextWord = BUS_ZERO;
                nextWord[8 + HDR_RESET_BIT] = result_q[chan_q].resetSeen;
                nextWord[8 + HDR_FAULT_BIT] = result_q[chan_q].digitalFault;
                nextWord[8 + HDR_OPEN_BIT]  = result_q[chan_q].openInput;
                nextWord[10:8]              = chan_q;
            end
            ST_ADC_CRC: begin
                nextWord = crc_q;
            end
            default: begin
                nextWord = BUS_ZERO;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            frame_q <= ST_ADC_DATA;
            chan_q  <= CHAN_TAG_FIRST;
            crc_q   <= CRC_SEED;
        end else if (busyFall || registerMode) begin
            frame_q <= ST_ADC_DATA;
            chan_q  <= CHAN_TAG_FIRST;
            crc_q   <= CRC_SEED;
        end else if (stepOk) begin
            case (frame_q)
                ST_ADC_DATA: begin
                    crc_q <= crcStep(crc_q, nextWord);
                    if (useStatus) begin
                        frame_q <= ST_ADC_STATUS;
                    end else if (chan_q == CHAN_TAG_LAST) begin
                        frame_q <= useCrc ? ST_ADC_CRC : ST_ADC_DATA;
                        chan_q  <= CHAN_TAG_FIRST;
                    end else begin
                        chan_q <= chan_q + 3'h1;
                    end
                end
                ST_ADC_STATUS: begin
                    crc_q <= crcStep(crc_q, nextWord);
                    if (chan_q == CHAN_TAG_LAST) begin
                        frame_q <= useCrc ? ST_ADC_CRC : ST_ADC_DATA;
                        chan_q  <= CHAN_TAG_FIRST;
                    end else begin
                        frame_q <= ST_ADC_DATA;
                        chan_q  <= chan_q + 3'h1;
                    end
                end
                ST_ADC_CRC: begin
                    frame_q <= ST_ADC_DATA;
                    crc_q   <= CRC_SEED;
                end
                default: begin
                    frame_q <= ST_ADC_DATA;
                end
            endcase
        end
    end

    // ************************************************************
    // Register mode commands.
    // ************************************************************
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            registerMode   <= 1'b0;
            regAddr        <= 7'h00;
            regWriteData   <= REG_RESET_VAL;
            regWriteStrobe <= 1'b0;
        end else begin
            regWriteStrobe <= 1'b0;
            if (!softwareMode || !parallelSel) begin
                registerMode <= 1'b0;
            end else if (wrRise) begin
                if (busIn_q == BUS_ZERO) begin
                    registerMode <= 1'b0;
                end else if (busIn_q[CMD_RW_BIT]) begin
                    registerMode <= 1'b1;
                    regAddr      <= busIn_q[CMD_ADDR_HI:CMD_ADDR_LO];
                end else if (registerMode) begin
                    regAddr        <= busIn_q[CMD_ADDR_HI:CMD_ADDR_LO];
                    regWriteData   <= busIn_q[7:0];
                    regWriteStrobe <= 1'b1;
                end
            end
        end
    end

    // ************************************************************
    // Bus and first-channel flag drivers.
    // ************************************************************
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            parallelDataBusOe  <= 1'b0;
            firstChannelFlagOe <= 1'b0;
        end else begin
            firstChannelFlagOe <= parallelSel && !strobe_q.nCs;
            if (registerMode) begin
                parallelDataBusOe <= !strobe_q.nCs && !strobe_q.nRd;
            end else begin
                // The bus is released while the host drives a command frame.
                parallelDataBusOe <= parallelSel && !strobe_q.nCs && strobe_q.nWr;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            parallelDataBusOut  <= BUS_ZERO;
            firstChannelFlagOut <= 1'b0;
        end else if (parallelSel && rdFall) begin
            if (registerMode) begin
                parallelDataBusOut  <= {1'b0, regAddr, regReadData};
                firstChannelFlagOut <= 1'b0;
            end else begin
                parallelDataBusOut  <= nextWord;
                firstChannelFlagOut <= (frame_q == ST_ADC_DATA) && (chan_q == CHAN_TAG_FIRST);
            end
        end
    end

endmodule // aphi_host_port

// >>> aphi_host_checker.sv
// Checker of the parallel host port outputs.
`timescale 1ns/1ps
module aphi_host_checker (
    input wire logic        mclk,
    input wire logic        rstn,
    input wire logic        interfaceSelectStrap,
    input wire logic [2:0]  oversamplingSelectPins,
    input wire logic        nCs,
    input wire logic        nRd,
    input wire logic        nWr,
    input wire logic        busy,
    input wire logic [15:0] parallelDataBusOut,
    input wire logic        parallelDataBusOe,
    input wire logic        firstChannelFlagOut,
    input wire logic        firstChannelFlagOe,
    input wire logic        regWriteStrobe,
    input wire logic        registerMode
);
    // ****************************************
    // Port assertions
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    sequence sCsIdle;
        nCs[*6];
    endsequence
    sequence sStrobe;
        $rose(regWriteStrobe);
    endsequence
    a_bus_float_cs: assert property (sCsIdle |-> !parallelDataBusOe)
        else $error("bus driven while deselected");
    a_flag_float_cs: assert property (sCsIdle |-> !firstChannelFlagOe)
        else $error("first flag driven while deselected");
    a_strap_quiet: assert property (interfaceSelectStrap[*6] |-> !parallelDataBusOe)
        else $error("bus driven with strap high");
    a_cs_drives: assert property ((!nCs && nWr && !interfaceSelectStrap && !registerMode)[*6]
        |-> parallelDataBusOe && firstChannelFlagOe) else $error("outputs not driven while selected");
    a_reg_read_only: assert property ((registerMode && nRd)[*6] |-> !parallelDataBusOe)
        else $error("register mode bus driven without read");
    a_word_stands: assert property ((nRd && nWr && !busy && !nCs)[*8] |=> $stable(parallelDataBusOut))
        else $error("bus word changed without read");
    a_strobe_one: assert property (sStrobe |=> !regWriteStrobe)
        else $error("write strobe longer than one cycle");
    a_write_in_reg: assert property (sStrobe |-> $past(registerMode, 2))
        else $error("write accepted outside register mode");
    a_mode_sw_only: assert property (registerMode |-> &oversamplingSelectPins)
        else $error("register mode outside software mode");
    a_flag_on_read: assert property ($rose(firstChannelFlagOut) |-> !nRd && !registerMode)
        else $error("first flag rose without read");
endmodule // aphi_host_checker

bind aphi_host_port aphi_host_checker aphi_host_checker_inst (.mclk(mclk), .rstn(rstn),
    .interfaceSelectStrap(interfaceSelectStrap), .oversamplingSelectPins(oversamplingSelectPins),
    .nCs(nCs), .nRd(nRd), .nWr(nWr), .busy(busy), .parallelDataBusOut(parallelDataBusOut),
    .parallelDataBusOe(parallelDataBusOe), .firstChannelFlagOut(firstChannelFlagOut),
    .firstChannelFlagOe(firstChannelFlagOe), .regWriteStrobe(regWriteStrobe), .registerMode(registerMode));

// >>> aphi_host_model.sv
// Host model that drives the strobes and its side of the shared bus.
`timescale 1ns/1ps
module aphi_host_model (
    input  wire logic        mclk,
    input  wire logic [15:0] devOut,
    input  wire logic        devOe,
    output logic             nCs,
    output logic             nRd,
    output logic             nWr,
    output logic      [15:0] busLevel
);
    // ****************************************
    // Bus cycles
    // ****************************************
    logic [15:0] hostData = 16'h0000;
    logic        hostOe = 1'b0;
    initial begin
        nCs = 1'b1;
        nRd = 1'b1;
        nWr = 1'b1;
    end
    // A released line shows the inverse of the host's last data word, never a stale copy.
    assign busLevel = devOe ? devOut : (hostOe ? hostData : ~hostData);
    task automatic sel(input logic v);
        @(negedge mclk);
        nCs = v;
        repeat (6) @(negedge mclk);
    endtask
    task automatic wr(input logic [15:0] w);
        @(negedge mclk);
        hostData = w;
        hostOe = 1'b1;
        nWr = 1'b0;
        repeat (6) @(negedge mclk);
        nWr = 1'b1;
        repeat (6) @(negedge mclk);
        hostOe = 1'b0;
        repeat (2) @(negedge mclk);
    endtask
    task automatic rd(input logic joined, output logic [15:0] w);
        @(negedge mclk);
        hostOe = 1'b0;
        nRd = 1'b0;
        if (joined) nCs = 1'b0;
        repeat (8) @(negedge mclk);
        w = busLevel;
        nRd = 1'b1;
        if (joined) nCs = 1'b1;
        repeat (6) @(negedge mclk);
    endtask
endmodule // aphi_host_model

// >>> aphi_host_port_test.sv
// Self-checking bench of the parallel host port.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin nTests++; if ((g) !== (e)) begin failures++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
module aphi_host_port_test;
    import aphi_pkg::*;
    // ****************************************
    // Stimulus and checks
    // ****************************************
    logic         mclk = 1'b0, rstn = 1'b0, strap = 1'b0, busy = 1'b0, sampleValid = 1'b0;
    logic         statusEnable = 1'b1, crcEnable = 1'b1;
    logic [2:0]   osPins = 3'h7;
    logic [7:0]   regReadData = 8'h00;
    aphi_sample_s sampleIn = '0;
    logic         nCs, nRd, nWr, busOe, flagOut, flagOe, sampleReady, wStrobe, regMode;
    logic [15:0]  busLevel, busOut, w, v, e;
    logic [6:0]   regAddr;
    logic [7:0]   regWriteData;
    logic [31:0]  lfsr = 32'h00010C83;
    logic [15:0]  expQ[$];
    int           failures = 0, nTests = 0, strobes = 0;
    always #10 mclk = ~mclk;
    always @(posedge mclk) if (wStrobe === 1'b1) strobes++;
    aphi_host_port aphi_host_port_inst (.mclk(mclk), .rstn(rstn), .interfaceSelectStrap(strap),
        .oversamplingSelectPins(osPins), .nCs(nCs), .nRd(nRd), .nWr(nWr), .busy(busy),
        .parallelDataBusIn(busLevel), .parallelDataBusOut(busOut), .parallelDataBusOe(busOe),
        .firstChannelFlagOut(flagOut), .firstChannelFlagOe(flagOe), .sampleIn(sampleIn),
        .sampleValid(sampleValid), .sampleReady(sampleReady), .statusEnable(statusEnable),
        .crcEnable(crcEnable), .regReadData(regReadData), .regAddr(regAddr),
        .regWriteData(regWriteData), .regWriteStrobe(wStrobe), .registerMode(regMode));
    aphi_host_model aphi_host_model_inst (.mclk(mclk), .devOut(busOut), .devOe(busOe), .nCs(nCs),
        .nRd(nRd), .nWr(nWr), .busLevel(busLevel));
    function automatic logic [15:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[15:0];
    endfunction
    function automatic logic [15:0] crcStep(input logic [15:0] c, input logic [15:0] d);
        logic fb;
        for (int i = 15; i >= 0; i--) begin
            fb = c[15] ^ d[i];
            c = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : BUS_ZERO);
        end
        return c;
    endfunction
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", nTests, failures);
        if (failures == 0 && nTests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Fills the FIFO with one burst while busy is high and queues the expected frames.
    task automatic loadBurst(input logic st, input logic cr);
        logic [15:0]  crc;
        aphi_sample_s s;
        crc = CRC_SEED;
        busy = 1'b1;
        sampleValid = 1'b1;
        for (int ch = 0; ch < CHAN_COUNT; ch++) begin
            w = rnd();
            s = {w, w[2:0]};
            sampleIn = s;
            repeat (20) if (sampleReady !== 1'b1) @(negedge mclk);
            if (sampleReady !== 1'b1) begin
                failures++;
                report_and_stop();
            end
            @(negedge mclk);
            expQ.push_back(s.value);
            crc = crcStep(crc, s.value);
            if (st) begin
                e = {s.resetSeen, s.digitalFault, s.openInput, 2'b00, 3'(ch), 8'h00};
                expQ.push_back(e);
                crc = crcStep(crc, e);
            end
        end
        sampleValid = 1'b0;
        if (cr) expQ.push_back(crc);
        `CHK("fifoFull", 1'b0, sampleReady)
        busy = 1'b0;
        repeat (30) @(negedge mclk);
    endtask
    initial begin
        repeat (16) @(negedge mclk);
        rstn = 1'b1;
        strap = 1'b1;
        aphi_host_model_inst.sel(1'b0);
        `CHK("strapOe", 1'b0, busOe)
        aphi_host_model_inst.sel(1'b1);
        strap = 1'b0;
        $display("test strap done");
        // Burst 0 is hardware mode, then both options, CRC only and status only.
        for (int p = 0; p < 4; p++) begin
            osPins = (p == 0) ? 3'h3 : 3'h7;
            statusEnable = (p != 2);
            crcEnable = (p != 3);
            loadBurst(p == 1 || p == 3, p == 1 || p == 2);
            if (p != 0) aphi_host_model_inst.sel(1'b0);
            `CHK("busOe", 1'(p != 0), busOe)
            `CHK("flagOe", 1'(p != 0), flagOe)
            for (int k = 0; expQ.size() > 0; k++) begin
                aphi_host_model_inst.rd(p == 0, w);
                e = expQ.pop_front();
                `CHK("word", e, w)
                `CHK("firstFlag", 1'(k == 0), flagOut)
            end
            if (p != 0) aphi_host_model_inst.sel(1'b1);
            `CHK("idleOe", 1'b0, busOe)
            `CHK("idleFlagOe", 1'b0, flagOe)
            $display("test burst %0d done", p);
        end
        aphi_host_model_inst.sel(1'b0);
        w = rnd();
        aphi_host_model_inst.wr({1'b0, w[14:0]});
        `CHK("adcWrite", 0, strobes)
        aphi_host_model_inst.wr({1'b1, w[14:8], 8'h00});
        `CHK("regMode", 1'b1, regMode)
        `CHK("regAddr", w[14:8], regAddr)
        regReadData = w[7:0];
        aphi_host_model_inst.rd(1'b0, v);
        `CHK("readback", {1'b0, w[14:8], regReadData}, v)
        aphi_host_model_inst.wr({1'b0, w[6:0], w[15:8]});
        `CHK("strobes", 1, strobes)
        `CHK("wrAddr", w[6:0], regAddr)
        `CHK("wrData", w[15:8], regWriteData)
        aphi_host_model_inst.wr(16'h0000);
        `CHK("exitMode", 1'b0, regMode)
        $display("test register done");
        report_and_stop();
    end
endmodule // aphi_host_port_test
